// *** rtl/gpib_aux_clear_eos_config.v ***
// Extended auxiliary command decoder with end-of-string configuration.
// Assumes an AHB-Lite master, one clock, and handshake logic outside
// that reports bus events as one-cycle pulses.
//
// Summary of operation
// RL1: Command 0x50 enters page-in state, exposing extra registers; here it only sets page_in, and the register map stays the same.
// RL2: Command 0x51 holds off RFD at once until finish handshake.
// RL3: Command 0x54 clears match-detect flag, bit 5 of status one.
// RL4: Command 0x55 clears END-received flag, bit 4 of status one.
// RL5: Command 0x56 clears device-clear flag, bit 3 of status one.
// RL6: Command 0x57 clears error flag, bit 2 of status one.
// RL7: Command 0x58 clears service-request flag when clear select is 1.
// RL8: Command 0x59 clears lockout-change flag, bit 2 of status two.
// RL9: Command 0x5A clears remote-change flag, bit 1 of status two.
// RL10: Command 0x5B clears address-status-change flag, bit 0 of status two.
// RL11: Command 0x5C clears interface-clear flag, bit 3 of status zero.
// RL12: Command 0x5D clears attention flag, bit 2 of status zero.
// RL13: Commands 0x5E and 0x5F reset and start the sync function.
// RL14: Port write with top bits 100 loads config from low five bits.
// RL15: Config clears on hardware reset and chip-reset command.
// RL16: Bit 4 picks eight-bit match, else seven-bit match.
// RL17: Talking with bit 3 set, matching output byte sends EOI.
// RL18: Bit 2 set: matching received byte sets END, acts as EOI.
// RL19: Bits 1:0 pick normal, hold all, hold on END, continuous.
// RL20: Listen-continuous forces continuous until listen command or LIDS.
// RL21: Flag set beats a same-cycle clear.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`include "gpib_aux_consts.vh"

module gpib_aux_clear_eos_config #(
    parameter AW = 8
) (
    input  wire          clock,
    input  wire          rst_n,
    input  wire          hsel,
    input  wire [31:0]   haddr,
    input  wire [1:0]    htrans,
    input  wire          hwrite,
    input  wire [2:0]    hsize,
    input  wire [31:0]   hwdata,
    input  wire          hready,
    output wire          hreadyout,
    output wire          hresp,
    output reg  [31:0]   hrdata,
    input  wire          ev_ifc,
    input  wire          ev_atn,
    input  wire          ev_device_clear,
    input  wire          ev_error,
    input  wire          ev_srq,
    input  wire          ev_lockout_change,
    input  wire          ev_remote_change,
    input  wire          ev_addr_change,
    input  wire          rx_valid,
    input  wire [7:0]    rx_byte,
    input  wire          rx_eoi,
    input  wire          talker_active,
    input  wire          listener_idle,
    output reg           rx_end,
    output wire [7:0]    tx_byte,
    output wire          tx_eoi,
    output reg           rfd_holdoff,
    output reg  [1:0]    rx_mode,
    output reg           page_in,
    output reg           sync_active
);

    // Stored state
    reg  [4:0]           cfg_q;
    reg  [3:0]           stat0_q;
    reg  [5:0]           stat1_q;
    reg  [6:0]           stat2_q;
    reg                  clr_sel_q;
    reg  [7:0]           eos_q;
    reg  [7:0]           dout_q;
    reg                  cont_q;
    reg                  wr_q;
    reg  [AW-1:0]        addr_q;

    // Decode helpers
    wire                 take;
    wire                 rd_take;
    wire                 wr_now;
    wire [7:0]           cmd;
    wire                 cmd_wr;
    wire                 cfg_wr;
    wire                 chip_rst;
    wire                 rx_match;
    wire                 tx_match;
    wire                 rx_end_now;
    wire [1:0]           mode_now;
    wire                 rd_stat0;
    wire                 rd_stat1;
    wire                 rd_stat2;

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase acceptance
    assign take    = hsel & htrans[`HTRANS_NONSEQ] & hready;
    assign rd_take = take & ~hwrite;

    // Address and direction held for the data phase
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_q   <= 1'b0;
            addr_q <= {AW{1'b0}};
        end else begin
            wr_q   <= take & hwrite;
            addr_q <= haddr[AW-1:0];
        end
    end

    // Write data phase decode
    assign wr_now = wr_q;
    assign cmd    = hwdata[7:0];
    assign cmd_wr = wr_now & (addr_q == `OFS_AUX_CMD);
    // RL14 config select
    assign cfg_wr   = cmd_wr & (cmd[7:5] == `CFG_SEL);
    assign chip_rst = cmd_wr & (cmd == `CMD_CHIP_RESET);

    // Clear-on-read strobes when command clearing is not selected
    assign rd_stat0 = rd_take & ~clr_sel_q & (haddr[AW-1:0] == `OFS_STAT_ZERO);
    assign rd_stat1 = rd_take & ~clr_sel_q & (haddr[AW-1:0] == `OFS_STAT_ONE);
    assign rd_stat2 = rd_take & ~clr_sel_q & (haddr[AW-1:0] == `OFS_STAT_TWO);

    // RL16 compare width
    assign rx_match = cfg_q[`CFG_EIGHT_BIT] ? (rx_byte == eos_q) :
                      ((rx_byte & `SEVEN_MASK) == (eos_q & `SEVEN_MASK));
    assign tx_match = cfg_q[`CFG_EIGHT_BIT] ? (dout_q == eos_q) :
                      ((dout_q & `SEVEN_MASK) == (eos_q & `SEVEN_MASK));

    // RL18 match counts as END
    assign rx_end_now = rx_valid & (rx_eoi | (cfg_q[`CFG_END_MATCH] & rx_match));

    // RL17 EOI with matching output byte
    assign tx_byte = dout_q;
    assign tx_eoi  = talker_active & cfg_q[`CFG_SEND_EOI] & tx_match;

    // RL20 forced continuous overrides holdoff bits
    assign mode_now = cont_q ? `MODE_CONT :
                      // RL19 holdoff bits select mode
                      {cfg_q[`CFG_HOLD_END], cfg_q[`CFG_HOLD_ALL]};

    // Configuration register
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `CFG_RESET;
        // RL15 chip reset clears
        end else if (chip_rst) begin
            cfg_q <= `CFG_RESET;
        // RL14 load fields
        end else if (cfg_wr) begin
            cfg_q <= cmd[4:0];
        end
    end

    // Software registers: clear select, end string, output data
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clr_sel_q <= 1'b0;
            eos_q     <= 8'h00;
            dout_q    <= 8'h00;
        end else begin
            if (wr_now & (addr_q == `OFS_CTRL)) begin
                clr_sel_q <= hwdata[0];
            end
            if (wr_now & (addr_q == `OFS_EOS)) begin
                eos_q <= hwdata[7:0];
            end
            if (wr_now & (addr_q == `OFS_DOUT)) begin
                dout_q <= hwdata[7:0];
            end
        end
    end

    // Continuous mode latch
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cont_q <= 1'b0;
        end else if (chip_rst) begin
            cont_q <= 1'b0;
        // RL20 set by listen-continuous
        end else if (cmd_wr & (cmd == `CMD_LTN_CONT)) begin
            cont_q <= 1'b1;
        // RL20 left by listen or LIDS
        end else if ((cmd_wr & (cmd == `CMD_LTN)) | listener_idle) begin
            cont_q <= 1'b0;
        end
    end

    // Page-in and sync state
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            page_in     <= 1'b0;
            sync_active <= 1'b0;
        end else if (chip_rst) begin
            page_in     <= 1'b0;
            sync_active <= 1'b0;
        end else begin
            // RL1 page-in entry
            if (cmd_wr & (cmd == `CMD_PAGE_IN)) begin
                page_in <= 1'b1;
            end
            // RL13 sync reset and start
            if (cmd_wr & (cmd == `CMD_SYNC_RST)) begin
                sync_active <= 1'b0;
            end else if (cmd_wr & (cmd == `CMD_SYNC_SET)) begin
                sync_active <= 1'b1;
            end
        end
    end

    // Acceptor holdoff and registered receive outputs
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rfd_holdoff <= 1'b0;
            rx_end      <= 1'b0;
            rx_mode     <= `MODE_NORMAL;
        end else begin
            rx_end  <= rx_end_now;
            rx_mode <= mode_now;
            if (chip_rst) begin
                rfd_holdoff <= 1'b0;
            // RL2 immediate holdoff
            end else if (cmd_wr & (cmd == `CMD_HOLD_NOW)) begin
                rfd_holdoff <= 1'b1;
            // RL19 holdoff on every byte
            end else if (rx_valid & (mode_now == `MODE_HOLD_ALL)) begin
                rfd_holdoff <= 1'b1;
            // RL19 holdoff on END byte
            end else if (rx_end_now & (mode_now == `MODE_HOLD_END)) begin
                rfd_holdoff <= 1'b1;
            // RL2 released by finish handshake
            end else if (cmd_wr & (cmd == `CMD_FINISH_HS)) begin
                rfd_holdoff <= 1'b0;
            end
        end
    end

    // Status register zero; set beats clear
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat0_q <= 4'h0;
        end else if (chip_rst) begin
            stat0_q <= 4'h0;
        end else begin
            // RL21 set wins
            if (ev_ifc) begin
                stat0_q[`STAT0_IFC] <= 1'b1;
            // RL11 clear interface clear
            end else if (rd_stat0 | (cmd_wr & (cmd == `CMD_CLR_IFC))) begin
                stat0_q[`STAT0_IFC] <= 1'b0;
            end
            if (ev_atn) begin
                stat0_q[`STAT0_ATN] <= 1'b1;
            // RL12 clear attention
            end else if (rd_stat0 | (cmd_wr & (cmd == `CMD_CLR_ATN))) begin
                stat0_q[`STAT0_ATN] <= 1'b0;
            end
        end
    end

    // Status register one; set beats clear
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat1_q <= 6'h00;
        end else if (chip_rst) begin
            stat1_q <= 6'h00;
        end else begin
            // RL21 set wins
            if (rx_valid & rx_match) begin
                stat1_q[`STAT1_MATCH] <= 1'b1;
            // RL3 clear match detect
            end else if (rd_stat1 | (cmd_wr & (cmd == `CMD_CLR_MATCH))) begin
                stat1_q[`STAT1_MATCH] <= 1'b0;
            end
            // RL18 END flag set
            if (rx_end_now) begin
                stat1_q[`STAT1_END] <= 1'b1;
            // RL4 clear END
            end else if (rd_stat1 | (cmd_wr & (cmd == `CMD_CLR_END))) begin
                stat1_q[`STAT1_END] <= 1'b0;
            end
            if (ev_device_clear) begin
                stat1_q[`STAT1_DEVCLR] <= 1'b1;
            // RL5 clear device clear
            end else if (rd_stat1 | (cmd_wr & (cmd == `CMD_CLR_DEVCLR))) begin
                stat1_q[`STAT1_DEVCLR] <= 1'b0;
            end
            if (ev_error) begin
                stat1_q[`STAT1_ERR] <= 1'b1;
            // RL6 clear error
            end else if (rd_stat1 | (cmd_wr & (cmd == `CMD_CLR_ERR))) begin
                stat1_q[`STAT1_ERR] <= 1'b0;
            end
        end
    end

    // Status register two; set beats clear
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat2_q <= 7'h00;
        end else if (chip_rst) begin
            stat2_q <= 7'h00;
        end else begin
            // RL21 set wins
            if (ev_srq) begin
                stat2_q[`STAT2_SRQ] <= 1'b1;
            // RL7 gated service-request clear
            end else if (rd_stat2 | (cmd_wr & clr_sel_q & (cmd == `CMD_CLR_SRQ))) begin
                stat2_q[`STAT2_SRQ] <= 1'b0;
            end
            if (ev_lockout_change) begin
                stat2_q[`STAT2_LOCK] <= 1'b1;
            // RL8 clear lockout change
            end else if (rd_stat2 | (cmd_wr & (cmd == `CMD_CLR_LOCK))) begin
                stat2_q[`STAT2_LOCK] <= 1'b0;
            end
            if (ev_remote_change) begin
                stat2_q[`STAT2_REMOTE] <= 1'b1;
            // RL9 clear remote change
            end else if (rd_stat2 | (cmd_wr & (cmd == `CMD_CLR_REMOTE))) begin
                stat2_q[`STAT2_REMOTE] <= 1'b0;
            end
            if (ev_addr_change) begin
                stat2_q[`STAT2_ADDR] <= 1'b1;
            // RL10 clear address change
            end else if (rd_stat2 | (cmd_wr & (cmd == `CMD_CLR_ADDR))) begin
                stat2_q[`STAT2_ADDR] <= 1'b0;
            end
        end
    end

    // Read data captured at the address phase
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            if (haddr[AW-1:0] == `OFS_STAT_ZERO) begin
                hrdata <= {28'h0000000, stat0_q};
            end else if (haddr[AW-1:0] == `OFS_STAT_ONE) begin
                hrdata <= {26'h0, stat1_q};
            end else if (haddr[AW-1:0] == `OFS_STAT_TWO) begin
                hrdata <= {25'h0, stat2_q};
            end else if (haddr[AW-1:0] == `OFS_CTRL) begin
                hrdata <= {31'h00000000, clr_sel_q};
            end else if (haddr[AW-1:0] == `OFS_EOS) begin
                hrdata <= {24'h000000, eos_q};
            end else if (haddr[AW-1:0] == `OFS_DOUT) begin
                hrdata <= {24'h000000, dout_q};
            end else if (haddr[AW-1:0] == `OFS_STATE) begin
                hrdata <= {26'h0, cont_q, rx_mode,
                           rfd_holdoff, sync_active, page_in};
            end else begin
                hrdata <= 32'h0000_0000; // Unmapped and write-only
            end
        end
    end

endmodule // gpib_aux_clear_eos_config

// *** shared/gpib_aux_consts.vh ***
// Constants for the auxiliary command decoder.
// Included by the decoder; holds definitions only.
`ifndef GPIB_AUX_CONSTS_VH
`define GPIB_AUX_CONSTS_VH
// Register byte offsets
`define OFS_AUX_CMD    8'h00
`define OFS_STAT_ZERO  8'h04
`define OFS_STAT_ONE   8'h08
`define OFS_STAT_TWO   8'h0c
`define OFS_CTRL       8'h10
`define OFS_EOS        8'h14
`define OFS_DOUT       8'h18
`define OFS_STATE      8'h1c
// Auxiliary command codes
`define CMD_CHIP_RESET 8'h02
`define CMD_FINISH_HS  8'h03
`define CMD_LTN        8'h0b
`define CMD_LTN_CONT   8'h1b
`define CMD_PAGE_IN    8'h50
`define CMD_HOLD_NOW   8'h51
`define CMD_CLR_MATCH  8'h54
`define CMD_CLR_END    8'h55
`define CMD_CLR_DEVCLR 8'h56
`define CMD_CLR_ERR    8'h57
`define CMD_CLR_SRQ    8'h58
`define CMD_CLR_LOCK   8'h59
`define CMD_CLR_REMOTE 8'h5a
`define CMD_CLR_ADDR   8'h5b
`define CMD_CLR_IFC    8'h5c
`define CMD_CLR_ATN    8'h5d
`define CMD_SYNC_RST   8'h5e
`define CMD_SYNC_SET   8'h5f
// Config register select and fields
`define CFG_SEL        3'h4
`define CFG_EIGHT_BIT  4
`define CFG_SEND_EOI   3
`define CFG_END_MATCH  2
`define CFG_HOLD_END   1
`define CFG_HOLD_ALL   0
`define CFG_RESET      5'h00
// Status bit positions
`define STAT0_IFC      3
`define STAT0_ATN      2
`define STAT1_MATCH    5
`define STAT1_END      4
`define STAT1_DEVCLR   3
`define STAT1_ERR      2
`define STAT2_SRQ      6
`define STAT2_LOCK     2
`define STAT2_REMOTE   1
`define STAT2_ADDR     0
// Receive modes
`define MODE_NORMAL    2'h0
`define MODE_HOLD_ALL  2'h1
`define MODE_HOLD_END  2'h2
`define MODE_CONT      2'h3
// Bus encodings
`define HTRANS_NONSEQ  1
`define SEVEN_MASK     8'h7f
`endif

// *** verification/gpib_aux_assertions.sv ***
// Checker: command decode and receive-path timing at the decoder ports.
// Assumes one clock, reset async active low, zero-wait bus slave.
`timescale 1ns/1ns
module gpib_aux_checker (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rx_valid,
    input wire logic        rx_eoi,
    input wire logic        talker_active,
    input wire logic        rx_end,
    input wire logic        tx_eoi,
    input wire logic        rfd_holdoff,
    input wire logic [1:0]  rx_mode,
    input wire logic        page_in,
    input wire logic        sync_active
);
    logic       cmd_wr_q;
    logic [4:0] cfg_q;
    // Marks the data phase of a command port write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_wr_q <= 1'b0;
        end else if (hready) begin
            cmd_wr_q <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
        end
    end
    // Shadow copy of the config fields
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= 5'h00;
        end else if (cmd_wr_q && hwdata[7:5] == 3'h4) begin
            cfg_q <= hwdata[4:0];
        end else if (cmd_wr_q && hwdata[7:0] == 8'h02) begin
            cfg_q <= 5'h00;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence cmd_s(logic [7:0] c);
        cmd_wr_q && hwdata[7:0] == c;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    page_in_a: assert property (cmd_s(8'h50) |=> page_in)
        else $error("page-in not entered");
    hold_now_a: assert property (cmd_s(8'h51) |=> rfd_holdoff)
        else $error("holdoff not taken at once");
    finish_hs_a: assert property (cmd_s(8'h03) && !rx_valid |=> !rfd_holdoff)
        else $error("holdoff kept after finish");
    sync_set_a: assert property (cmd_s(8'h5f) |=> sync_active)
        else $error("sync not started");
    sync_clear_a: assert property (cmd_s(8'h5e) |=> !sync_active)
        else $error("sync not reset");
    chip_reset_a: assert property (cmd_s(8'h02) |=> !page_in && !sync_active)
        else $error("chip reset left state");
    end_eoi_a: assert property (rx_valid && rx_eoi |=> rx_end)
        else $error("end not flagged");
    end_cause_a: assert property (rx_end |-> $past(rx_valid))
        else $error("end without byte");
    eoi_gate_a: assert property (tx_eoi |-> talker_active && cfg_q[3])
        else $error("eoi sent while not allowed");
    mode_cont_a: assert property (cmd_s(8'h1b) |-> ##[1:2] rx_mode == 2'h3)
        else $error("continuous mode not forced");
endmodule // gpib_aux_checker

bind gpib_aux_clear_eos_config gpib_aux_checker chk (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .rx_valid(rx_valid), .rx_eoi(rx_eoi),
    .talker_active(talker_active), .rx_end(rx_end), .tx_eoi(tx_eoi),
    .rfd_holdoff(rfd_holdoff), .rx_mode(rx_mode), .page_in(page_in),
    .sync_active(sync_active)
);

// *** verification/gpib_aux_clear_eos_config_test.sv ***
// Bench: bus read/write tasks and command scenarios for the decoder.
// Assumes the far-side model and a zero-wait slave answer.
`timescale 1ns/1ns
module gpib_aux_clear_eos_config_test;
    logic        clock = 0;
    logic        rst_n = 0;
    logic        hsel = 1;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 0;
    logic [1:0]  htrans = 0;
    logic        hwrite = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] hrdata;
    logic [7:0]  ev, rx_byte, tx_byte;
    logic        hreadyout, hresp, rx_valid, rx_eoi, talk, lids;
    logic        rx_end, tx_eoi, rfd_holdoff, page_in, sync_active;
    logic [1:0]  rx_mode;
    int          miscompares = 0;
    int          samples_checked = 0;
    logic [7:0]  cd [10] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h58,
                             8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d};
    logic [7:0]  ad [10] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0c,
                             8'h0c, 8'h0c, 8'h0c, 8'h04, 8'h04};
    int          bt [10] = '{5, 4, 3, 2, 6, 2, 1, 0, 3, 2};

    gpib_aux_clear_eos_config uut (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ev_ifc(ev[6]), .ev_atn(ev[7]), .ev_device_clear(ev[0]), .ev_error(ev[1]),
        .ev_srq(ev[2]), .ev_lockout_change(ev[3]), .ev_remote_change(ev[4]),
        .ev_addr_change(ev[5]), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_eoi(rx_eoi), .talker_active(talk), .listener_idle(lids),
        .rx_end(rx_end), .tx_byte(tx_byte), .tx_eoi(tx_eoi),
        .rfd_holdoff(rfd_holdoff), .rx_mode(rx_mode), .page_in(page_in),
        .sync_active(sync_active)
    );
    gpib_far_side m (
        .clock(clock), .ev(ev), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_eoi(rx_eoi), .talk(talk), .lids(lids)
    );

    // Free-running clock
    always #5 clock = ~clock;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t: got %h want %h", $time, s, e);
        end
    endtask
    // Waits for hready under a bound
    task automatic wait_rdy(inout int n);
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            check(0, 1);
            give_verdict();
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy(n);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(n);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        check(r, e);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk_rd(8'h1c, 32'h0);
        wr(8'h00, 32'h50);
        chk_rd(8'h1c, 32'h1);
        wr(8'h00, 32'h51);
        chk_rd(8'h1c, 32'h5);
        wr(8'h00, 32'h03);
        chk_rd(8'h1c, 32'h1);
        wr(8'h00, 32'h5f);
        chk_rd(8'h1c, 32'h3);
        wr(8'h00, 32'h5e);
        chk_rd(8'h1c, 32'h1);
        $display("test commands done");
        wr(8'h10, 32'h1);
        wr(8'h14, 32'h41);
        for (int i = 0; i < 10; i++) begin
            if (i < 2) m.send(i ? 8'h00 : 8'h41, i[0]);
            else m.pulse(i - 2);
            chk_rd(ad[i], 32'h1 << bt[i]);
            wr(8'h00, {24'h0, cd[i]});
            chk_rd(ad[i], 32'h0);
        end
        // Event lands on the edge of its own clear command
        fork
            wr(8'h00, 32'h5c);
            begin
                @(posedge clock);
                m.pulse(6);
            end
        join
        chk_rd(8'h04, 32'h8);
        // Clear select off: 0x58 ignored, read clears
        wr(8'h10, 32'h0);
        m.pulse(2);
        wr(8'h00, 32'h58);
        chk_rd(8'h0c, 32'h40);
        chk_rd(8'h0c, 32'h0);
        $display("test clears done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, 32'h80 | k);
            // Reported mode lags the config by one cycle
            @(posedge clock);
            chk_rd(8'h1c, (k << 3) | 1);
        end
        wr(8'h00, 32'h80);
        wr(8'h00, 32'h1b);
        @(posedge clock);
        chk_rd(8'h1c, 32'h39);
        wr(8'h00, 32'h0b);
        @(posedge clock);
        chk_rd(8'h1c, 32'h1);
        wr(8'h00, 32'h1b);
        m.levels(1'b0, 1'b1);
        repeat (2) @(posedge clock);
        m.levels(1'b0, 1'b0);
        chk_rd(8'h1c, 32'h1);
        // Holdoff on every byte, then on END bytes only
        wr(8'h00, 32'h81);
        m.send(8'h00, 1'b0);
        chk_rd(8'h1c, 32'hd);
        wr(8'h00, 32'h03);
        wr(8'h00, 32'h82);
        m.send(8'h00, 1'b0);
        chk_rd(8'h1c, 32'h11);
        m.send(8'h00, 1'b1);
        chk_rd(8'h1c, 32'h15);
        wr(8'h00, 32'h03);
        chk_rd(8'h08, 32'h10);
        $display("test modes done");
        wr(8'h14, 32'h8a);
        wr(8'h00, 32'h84);
        m.send(8'h0a, 1'b0);
        chk_rd(8'h08, 32'h30);
        wr(8'h00, 32'h02);
        chk_rd(8'h1c, 32'h0);
        chk_rd(8'h08, 32'h0);
        wr(8'h10, 32'h1);
        wr(8'h00, 32'h94);
        m.send(8'h0a, 1'b0);
        chk_rd(8'h08, 32'h0);
        wr(8'h18, 32'h0a);
        wr(8'h00, 32'h88);
        m.levels(1'b1, 1'b0);
        @(negedge clock);
        check({31'h0, tx_eoi}, 32'h1);
        @(posedge clock);
        wr(8'h00, 32'h98);
        @(negedge clock);
        check({31'h0, tx_eoi}, 32'h0);
        @(posedge clock);
        wr(8'h00, 32'h88);
        m.levels(1'b0, 1'b0);
        @(negedge clock);
        check({31'h0, tx_eoi}, 32'h0);
        $display("test end string done");
        give_verdict();
    end
endmodule // gpib_aux_clear_eos_config_test

// *** verification/gpib_far_side.sv ***
// Far-side model: bus events and received bytes as one-cycle pulses.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ns
module gpib_far_side (
    input  wire logic  clock,
    output logic [7:0] ev,
    output logic       rx_valid,
    output logic [7:0] rx_byte,
    output logic       rx_eoi,
    output logic       talk,
    output logic       lids
);
    // Idle levels
    initial begin
        ev = 8'h00;
        rx_valid = 1'b0;
        rx_byte = 8'h5a;
        rx_eoi = 1'b0;
        talk = 1'b0;
        lids = 1'b0;
    end
    // One event strobe of one cycle
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev <= 8'h00;
    endtask
    // One byte; data turns over once the strobe drops
    task automatic send(input logic [7:0] b, input logic e);
        rx_byte <= b;
        rx_eoi <= e;
        rx_valid <= 1'b1;
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
        rx_eoi <= ~e;
    endtask
    // Talker and listener-idle levels
    task automatic levels(input logic t, input logic l);
        talk <= t;
        lids <= l;
    endtask
endmodule // gpib_far_side
